// ### design/std_timer_regs.svh
`ifndef STD_TIMER_REGS_SVH
`define STD_TIMER_REGS_SVH

// ----------------------------------------------------------------
// Operating mode codes
// ----------------------------------------------------------------
`define MODE_COMPARE      2'h0
`define MODE_CAPTURE      2'h1
`define MODE_PWM_PULSE    2'h2
`define MODE_TIMER        2'h3

// ----------------------------------------------------------------
// Pin function codes, output modes
// ----------------------------------------------------------------
`define PIN_FORCE_INACT   2'h0
`define PIN_FORCE_ACT     2'h1
`define PIN_PWM           2'h2
`define PIN_ONE_SHOT      2'h3

// ----------------------------------------------------------------
// Pin function codes, capture mode
// ----------------------------------------------------------------
`define CAP_RISE          2'h0
`define CAP_FALL          2'h1
`define CAP_BOTH          2'h2
`define CAP_OFF           2'h3

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define COUNT_W           16
`define DUTY_W            17
`define P_ZERO            8'h00
`define LOW_BYTE_ZERO     8'h00
`define COUNT_RST         16'h0000
`define COUNT_ONE         16'h0001
`define FULL_SCALE        17'h10000

`endif

// ### design/std_timer_pkg.sv
package std_timer_pkg;

  // ----------------------------------------------------------------
  // Control bits written by software
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] op_mode_field;
    logic [1:0] pin_function_field;
    logic       output_level_select;
    logic       output_polarity;
    logic       duty_period_swap;
    logic       counter_clear_source;
  } ctrl_type;

  // ----------------------------------------------------------------
  // Sticky event flags
  // ----------------------------------------------------------------
  typedef struct packed {
    logic compare_a_flag;
    logic compare_p_flag;
  } flags_type;

endpackage

// ### design/pin_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync_edge #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic pin_in,
  output logic      rise_out,
  output logic      fall_out
);

  // ----------------------------------------------------------------
  // Synchroniser chain and edge history
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] sync;
  logic                   last;

  if (SYNC_STAGES < 2) begin : bad_stages
    $error("pin_sync_edge needs at least two stages");
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync <= '0;
      last <= 1'b0;
    end else begin
      sync <= {sync[SYNC_STAGES-2:0], pin_in};
      last <= sync[SYNC_STAGES-1];
    end
  end

  assign rise_out = sync[SYNC_STAGES-1] & ~last;
  assign fall_out = ~sync[SYNC_STAGES-1] & last;

endmodule

`default_nettype wire

// ### design/std_timer_pwm_pulse_capture.sv
// Operation
// - Swap set: A match clears counter, duty is P times 256, zero means 65536.
// - Counting and compares go on while pin is forced inactive or active.
// - PWM ignores clear source; swap bit alone picks the period comparator.
// - Mode 10 with pin function 11 selects one-shot pulse output.
// - One-shot starts on run rising, by software or external trigger edge.
// - Run rising in one-shot starts counter and pulse leading edge together.
// - Pulse ends on software run clear or A match, which clears run.
// - One-shot A match sets the compare A flag and interrupt request.
// - One-shot clears counter only on run rising; ignores P, clear source, swap.
// - Mode 01 is capture; counter starts when software raises run.
// - Capture edge chosen by pin function; 11 disables capture, counter runs.
// - Selected capture edge copies counter into compare A, raises interrupt.
// - Capture mode counter runs until run falls, cleared on P match.
// - Capture P match clears counter, raises interrupt; P zero gives full count.
// - Capture pulses narrower than two timer clocks may be missed.
// - Counter latched within three timer clocks, flag set one clock later.
// - Capture mode drives no output; level, polarity, clear, swap ignored.
// - Duty at or above period holds output active whole period.
// - In compare mode each run rising edge drives the output to its active level (level select XOR polarity).
`timescale 1ns/100ps
`default_nettype none
`include "std_timer_regs.svh"

module std_timer_pwm_pulse_capture #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  input  wire std_timer_pkg::ctrl_type   ctrl_in,
  input  wire logic                      count_tick_in,
  input  wire logic                      run_wr_in,
  input  wire logic                      run_wdata_in,
  input  wire logic                      ext_trigger_falling_in,
  input  wire logic [15:0]               compare_a_wdata_in,
  input  wire logic                      compare_a_wr_in,
  input  wire logic [7:0]                compare_value_p_in,
  input  wire std_timer_pkg::flags_type  flags_clr_in,
  input  wire logic                      ext_trigger_clock_pin_in,
  input  wire logic                      capture_input_pin_in,
  output logic                           counter_run_out,
  output logic [15:0]                    counter_value_out,
  output logic [15:0]                    compare_value_a_out,
  output std_timer_pkg::flags_type       flags_out,
  output logic                           timer_irq_out,
  output logic                           pulse_pin_out,
  output logic                           pin_function_active_out
);

  import std_timer_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [`DUTY_W-1:0] p_span(input logic [7:0] p);
    if (p == `P_ZERO) begin
      p_span = `FULL_SCALE;
    end else begin
      p_span = {1'b0, p, `LOW_BYTE_ZERO};
    end
  endfunction

  function automatic logic level_of(input logic active, input logic act_high, input logic invert);
    level_of = (active ? act_high : ~act_high) ^ invert;
  endfunction

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (SYNC_STAGES < 2) begin : bad_sync
    $error("SYNC_STAGES must be at least two");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic              counter_run;
  logic              run_prev;
  logic [15:0]       counter;
  logic [15:0]       compare_value_a;
  logic              capture_pending;
  logic              compare_a_flag;
  logic              compare_p_flag;
  logic              pin_level;
  logic              irq;

  logic              next_counter_run;
  logic [15:0]       next_counter;
  logic [15:0]       next_compare_value_a;
  logic              next_pin_level;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic trig_rise;
  logic trig_fall;
  logic cap_rise;
  logic cap_fall;

  pin_sync_edge #(
    .SYNC_STAGES (SYNC_STAGES)
  ) trig_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (ext_trigger_clock_pin_in),
    .rise_out   (trig_rise),
    .fall_out   (trig_fall)
  );

  pin_sync_edge #(
    .SYNC_STAGES (SYNC_STAGES)
  ) cap_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (capture_input_pin_in),
    .rise_out   (cap_rise),
    .fall_out   (cap_fall)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire mode_capture  = (ctrl_in.op_mode_field == `MODE_CAPTURE);
  wire mode_pwm_grp  = (ctrl_in.op_mode_field == `MODE_PWM_PULSE);
  wire mode_one_shot = mode_pwm_grp && (ctrl_in.pin_function_field == `PIN_ONE_SHOT);
  wire mode_pwm      = mode_pwm_grp && !mode_one_shot;
  wire mode_compare  = (ctrl_in.op_mode_field == `MODE_COMPARE);
  wire mode_output   = mode_pwm_grp || mode_compare;

  // ----------------------------------------------------------------
  // Run edges and compare matches
  // ----------------------------------------------------------------
  wire        run_rise   = counter_run && !run_prev;
  wire        step       = counter_run && !run_rise && count_tick_in;
  wire [15:0] count_plus = counter + `COUNT_ONE;
  wire [15:0] p_target   = {compare_value_p_in, `LOW_BYTE_ZERO};
  wire        match_a    = step && (count_plus == compare_value_a);
  wire        match_p    = step && (count_plus == p_target);

  // Period and clear selection per mode
  wire pwm_clear     = ctrl_in.duty_period_swap ? match_a : match_p;
  wire other_clear   = ctrl_in.counter_clear_source ? match_a : match_p;
  wire capture_clear = match_p;
  wire count_clear   = mode_one_shot ? 1'b0 :
                       mode_pwm      ? pwm_clear :
                       mode_capture  ? capture_clear :
                                       other_clear;

  // ----------------------------------------------------------------
  // One-shot trigger and stop
  // ----------------------------------------------------------------
  wire trig_edge     = ext_trigger_falling_in ? trig_fall : trig_rise;
  wire shot_trigger  = mode_one_shot && trig_edge && !counter_run;
  wire shot_stop     = mode_one_shot && match_a;

  always_comb begin
    next_counter_run = counter_run;
    if (run_wr_in) begin
      next_counter_run = run_wdata_in;
    end
    if (shot_trigger) begin
      next_counter_run = 1'b1;
    end
    if (shot_stop) begin
      next_counter_run = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    next_counter = counter;
    if (run_rise) begin
      next_counter = `COUNT_RST;
    end else if (step) begin
      if (count_clear) begin
        next_counter = `COUNT_RST;
      end else begin
        next_counter = count_plus;
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture edge select and latch
  // ----------------------------------------------------------------
  wire cap_sel_rise = (ctrl_in.pin_function_field == `CAP_RISE) ||
                      (ctrl_in.pin_function_field == `CAP_BOTH);
  wire cap_sel_fall = (ctrl_in.pin_function_field == `CAP_FALL) ||
                      (ctrl_in.pin_function_field == `CAP_BOTH);
  wire cap_edge     = (cap_sel_rise && cap_rise) || (cap_sel_fall && cap_fall);
  wire cap_take     = mode_capture && cap_edge;

  always_comb begin
    next_compare_value_a = compare_value_a;
    if (compare_a_wr_in) begin
      next_compare_value_a = compare_a_wdata_in;
    end
    if (cap_take) begin
      next_compare_value_a = counter;
    end
  end

  // ----------------------------------------------------------------
  // Flag events
  // ----------------------------------------------------------------
  wire set_a_flag = capture_pending ||
                    (!mode_capture && match_a);
  wire set_p_flag = !mode_one_shot &&
                    match_p &&
                    !(mode_compare && ctrl_in.counter_clear_source) &&
                    !(ctrl_in.op_mode_field == `MODE_TIMER && ctrl_in.counter_clear_source);

  // ----------------------------------------------------------------
  // Output waveform
  // ----------------------------------------------------------------
  wire [`DUTY_W-1:0] duty_a   = {1'b0, compare_value_a};
  wire [`DUTY_W-1:0] duty_p   = p_span(compare_value_p_in);
  wire [`DUTY_W-1:0] duty     = ctrl_in.duty_period_swap ? duty_p : duty_a;
  wire [`DUTY_W-1:0] count_x  = {1'b0, next_counter};
  wire               pwm_act  = (count_x < duty);
  wire               act_high = ctrl_in.output_level_select;
  wire               invert   = ctrl_in.output_polarity;

  always_comb begin
    next_pin_level = pin_level;
    if (mode_one_shot) begin
      next_pin_level = level_of(next_counter_run, act_high, invert);
    end else if (mode_pwm) begin
      case (ctrl_in.pin_function_field)
        `PIN_FORCE_INACT: next_pin_level = level_of(1'b0, act_high, invert);
        `PIN_FORCE_ACT:   next_pin_level = level_of(1'b1, act_high, invert);
        `PIN_PWM:         next_pin_level = level_of(pwm_act, act_high, invert);
        default:          next_pin_level = pin_level;
      endcase
    end else if (mode_compare) begin
      if (run_rise) begin
        next_pin_level = act_high ^ invert;
      end
    end else begin
      next_pin_level = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      counter_run <= 1'b0;
      run_prev    <= 1'b0;
    end else begin
      counter_run <= next_counter_run;
      run_prev    <= counter_run;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      counter         <= `COUNT_RST;
      compare_value_a <= `COUNT_RST;
    end else begin
      counter         <= next_counter;
      compare_value_a <= next_compare_value_a;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      capture_pending <= 1'b0;
    end else begin
      capture_pending <= cap_take;
    end
  end

  // Sticky flags, a set in the clearing cycle wins
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
      irq            <= 1'b0;
    end else begin
      compare_a_flag <= set_a_flag | (compare_a_flag & ~flags_clr_in.compare_a_flag);
      compare_p_flag <= set_p_flag | (compare_p_flag & ~flags_clr_in.compare_p_flag);
      irq            <= set_a_flag | set_p_flag;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_level <= 1'b0;
    end else begin
      pin_level <= next_pin_level;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign counter_run_out          = counter_run;
  assign counter_value_out        = counter;
  assign compare_value_a_out      = compare_value_a;
  assign flags_out.compare_a_flag = compare_a_flag;
  assign flags_out.compare_p_flag = compare_p_flag;
  assign timer_irq_out            = irq;
  assign pulse_pin_out            = pin_level;
  assign pin_function_active_out  = mode_output;

endmodule

`default_nettype wire

// ### dv/std_timer_sva.sv
`timescale 1ns/100ps
`default_nettype none

module std_timer_sva (
  input wire logic                     clk_in,
  input wire logic                     sys_rst_in,
  input wire std_timer_pkg::ctrl_type  ctrl_in,
  input wire logic                     run_wr_in,
  input wire logic                     run_wdata_in,
  input wire logic                     compare_a_wr_in,
  input wire logic [7:0]               compare_value_p_in,
  input wire logic                     counter_run_out,
  input wire logic [15:0]              counter_value_out,
  input wire logic [15:0]              compare_value_a_out,
  input wire std_timer_pkg::flags_type flags_out,
  input wire logic                     timer_irq_out,
  input wire logic                     pulse_pin_out
);
  import std_timer_pkg::*;
  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire logic        pwm_mode = ctrl_in.op_mode_field == 2'h2;
  wire logic        one_shot = pwm_mode && ctrl_in.pin_function_field == 2'h3;
  wire logic        capture  = ctrl_in.op_mode_field == 2'h1;
  wire logic        act_lvl  = ctrl_in.output_level_select ^ ctrl_in.output_polarity;
  wire logic [16:0] duty_p   = (compare_value_p_in == 8'h00) ? 17'h10000 : {1'b0, compare_value_p_in, 8'h00};
  wire logic        full     = pwm_mode && ctrl_in.pin_function_field == 2'h2 && ctrl_in.duty_period_swap &&
                               duty_p >= {1'b0, compare_value_a_out};
  wire logic        forced   = pwm_mode && !ctrl_in.pin_function_field[1] && counter_run_out;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_run_write;
    run_wr_in && run_wdata_in && !counter_run_out;
  endsequence
  sequence s_run_started;
    counter_run_out && counter_value_out == 16'h0000;
  endsequence
  sequence s_cap_latch;
    capture && $changed(compare_value_a_out) && !$past(compare_a_wr_in);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RUN_START: assert property (s_run_write |=> counter_run_out ##1 s_run_started)
    else $error("run write did not start a cleared counter");
  AST_RISE_CLEAR: assert property ($rose(counter_run_out) |=> counter_value_out == 16'h0000)
    else $error("counter not zero on run rise");
  AST_ONE_LEAD: assert property (one_shot && $rose(counter_run_out) |-> pulse_pin_out == act_lvl)
    else $error("pulse leading edge missing");
  AST_ONE_TRAIL: assert property (one_shot && $fell(counter_run_out) |-> pulse_pin_out == !act_lvl)
    else $error("pulse trailing edge missing");
  AST_ONE_MATCH: assert property (one_shot && $fell(counter_run_out) && !$past(run_wr_in)
    |-> flags_out.compare_a_flag && timer_irq_out)
    else $error("match end without flag and request");
  AST_CAP_FLAG: assert property (s_cap_latch |=> flags_out.compare_a_flag && timer_irq_out)
    else $error("capture flag not one cycle after latch");
  AST_CAP_PIN: assert property (capture [*2] |-> !pulse_pin_out)
    else $error("pin driven in capture mode");
  AST_IRQ: assert property ($rose(flags_out.compare_a_flag) || $rose(flags_out.compare_p_flag) |-> timer_irq_out)
    else $error("flag set without request");
  AST_PWM_FULL: assert property ((full && counter_run_out) [*3] |-> pulse_pin_out == act_lvl)
    else $error("full duty not held active");
  AST_PWM_PERIOD: assert property (pwm_mode && !one_shot && ctrl_in.duty_period_swap && counter_run_out &&
    $past(counter_run_out) && $past(counter_run_out, 2) &&
    compare_value_a_out != 16'h0000 |-> counter_value_out < compare_value_a_out)
    else $error("counter passed period value");
  AST_FORCED: assert property (forced [*3] |-> pulse_pin_out == (ctrl_in.pin_function_field[0] ? act_lvl : !act_lvl))
    else $error("forced level wrong");
endmodule

bind std_timer_pwm_pulse_capture std_timer_sva u_sva (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ctrl_in(ctrl_in),
  .run_wr_in(run_wr_in), .run_wdata_in(run_wdata_in), .compare_a_wr_in(compare_a_wr_in),
  .compare_value_p_in(compare_value_p_in), .counter_run_out(counter_run_out), .counter_value_out(counter_value_out),
  .compare_value_a_out(compare_value_a_out), .flags_out(flags_out), .timer_irq_out(timer_irq_out),
  .pulse_pin_out(pulse_pin_out));

`default_nettype wire

// ### dv/pin_partner.sv
`timescale 1ns/100ps
`default_nettype none

module pin_partner (
  input  wire logic clk_in,
  input  wire logic trig_fall_in,
  output logic      trig_pin_out,
  output logic      cap_pin_out
);
  logic trig_hold = 1'b0;
  // Idle level follows the active edge so one pulse gives one trigger
  assign trig_pin_out = trig_fall_in ^ trig_hold;
  initial cap_pin_out = 1'b0;

  // Pulses are kept wider than two timer clocks
  task automatic pulse_trig(input int w);
    @(posedge clk_in);
    trig_hold <= 1'b1;
    repeat (w) @(posedge clk_in);
    trig_hold <= 1'b0;
  endtask

  task automatic pulse_cap(input int w, input int gap);
    @(posedge clk_in);
    cap_pin_out <= 1'b1;
    repeat (w) @(posedge clk_in);
    cap_pin_out <= 1'b0;
    repeat (gap) @(posedge clk_in);
  endtask
endmodule

`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "std_timer_regs.svh"

module tb;
  import std_timer_pkg::*;
  logic        clk_in                 = 1'b0;
  logic        sys_rst_in             = 1'b1;
  ctrl_type    ctrl_in                = '0;
  logic        count_tick_in          = 1'b1;
  logic        run_wr_in              = 1'b0;
  logic        run_wdata_in           = 1'b0;
  logic        ext_trigger_falling_in = 1'b0;
  logic [15:0] compare_a_wdata_in     = 16'h0000;
  logic        compare_a_wr_in        = 1'b0;
  logic [7:0]  compare_value_p_in     = 8'h00;
  flags_type   flags_clr_in           = '0;
  wire logic   trig_pin;
  wire logic   cap_pin;
  logic        counter_run_out;
  logic [15:0] counter_value_out;
  logic [15:0] compare_value_a_out;
  flags_type   flags_out;
  logic        timer_irq_out;
  logic        pulse_pin_out;
  logic        pfa;
  int          n_fail                 = 0;
  int          num_checks             = 0;
  logic [31:0] seed                   = 32'hA3A770AD;
  int          n;
  int          i0;
  int          w;
  logic [15:0] a;

  always #5 clk_in = ~clk_in;

  std_timer_pwm_pulse_capture DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ctrl_in(ctrl_in),
    .count_tick_in(count_tick_in), .run_wr_in(run_wr_in), .run_wdata_in(run_wdata_in),
    .ext_trigger_falling_in(ext_trigger_falling_in), .compare_a_wdata_in(compare_a_wdata_in),
    .compare_a_wr_in(compare_a_wr_in), .compare_value_p_in(compare_value_p_in), .flags_clr_in(flags_clr_in),
    .ext_trigger_clock_pin_in(trig_pin), .capture_input_pin_in(cap_pin), .counter_run_out(counter_run_out),
    .counter_value_out(counter_value_out), .compare_value_a_out(compare_value_a_out), .flags_out(flags_out),
    .timer_irq_out(timer_irq_out), .pulse_pin_out(pulse_pin_out), .pin_function_active_out(pfa));

  pin_partner partner (.clk_in(clk_in), .trig_fall_in(ext_trigger_falling_in), .trig_pin_out(trig_pin),
    .cap_pin_out(cap_pin));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic lvl(input logic act);
    return (act ? ctrl_in.output_level_select : !ctrl_in.output_level_select) ^ ctrl_in.output_polarity;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  task automatic wr_run(input logic v);
    @(posedge clk_in);
    run_wr_in <= 1'b1;
    run_wdata_in <= v;
    @(posedge clk_in);
    run_wr_in <= 1'b0;
    #1;
  endtask

  task automatic wr_a(input logic [15:0] v);
    @(posedge clk_in);
    compare_a_wr_in <= 1'b1;
    compare_a_wdata_in <= v;
    @(posedge clk_in);
    compare_a_wr_in <= 1'b0;
  endtask

  task automatic cfg(input logic [1:0] m, input logic [1:0] f, input logic s);
    logic [31:0] r;
    r = rnd();
    wr_run(1'b0);
    @(posedge clk_in);
    ctrl_in <= {m, f, r[2:1], s, r[0]};
    flags_clr_in <= '1;
    @(posedge clk_in);
    flags_clr_in <= '0;
    wr_run(1'b1);
  endtask

  task automatic count_act(input int k, output int c);
    c = 0;
    repeat (k) begin
      step(1);
      if (pulse_pin_out === lvl(1'b1)) c++;
    end
  endtask

  task automatic watch(input int k);
    for (int i = 0; i < k; i++) begin
      step(1);
      flags_clr_in <= {timer_irq_out, timer_irq_out};
      if (timer_irq_out === 1'b1) begin
        n++;
        if (i0 < 0) i0 = i;
        if (flags_out.compare_a_flag === 1'b1) chk(compare_value_a_out, counter_value_out - 16'h0002);
      end
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200us;
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    ext_trigger_falling_in = 1'(rnd());
    step(5);
    sys_rst_in <= 1'b0;
    step(1);
    chk({counter_run_out, timer_irq_out, pulse_pin_out, flags_out}, 32'h0);
    chk({counter_value_out, compare_value_a_out}, 32'h0);
    chk(pfa, 1'b1);
    $display("test reset done");
    // Period by A and duty by P, then period by P and duty by A; clear source is random
    compare_value_p_in <= 8'h01;
    wr_a(16'h0258);
    cfg(`MODE_PWM_PULSE, `PIN_PWM, 1'b1);
    step(50);
    count_act(1200, n);
    chk(n, 2 * 256);
    compare_value_p_in <= 8'h02;
    wr_a(16'h0080);
    cfg(`MODE_PWM_PULSE, `PIN_PWM, 1'b0);
    step(50);
    count_act(1024, n);
    chk(n, 2 * 128);
    compare_value_p_in <= `P_ZERO;
    wr_a(16'h0014);
    for (int f = 0; f < 3; f++) begin
      cfg(`MODE_PWM_PULSE, 2'(f), 1'b1);
      step(5);
      count_act(40, n);
      chk(n, (f == 0) ? 0 : 40);
      chk(flags_out.compare_a_flag, 1'b1);
      chk(pfa, 1'b1);
    end
    $display("test pwm done");
    // Pin function stays at one-shot while the mode is in use
    compare_value_p_in <= 8'(rnd());
    a = 16'h0014 + 16'(rnd() & 32'h1F);
    wr_a(a);
    cfg(`MODE_PWM_PULSE, `PIN_ONE_SHOT, 1'(rnd()));
    chk(pulse_pin_out, lvl(1'b1));
    w = 0;
    while (counter_run_out === 1'b1 && w < 200) begin
      w++;
      step(1);
    end
    chk(w, a + 1);
    chk({pulse_pin_out, flags_out.compare_a_flag}, {lvl(1'b0), 1'b1});
    w = 0;
    fork
      partner.pulse_trig(4);
      while (counter_run_out !== 1'b1 && w < 20) begin
        w++;
        step(1);
      end
    join
    chk({counter_run_out, pulse_pin_out}, {1'b1, lvl(1'b1)});
    step(3);
    wr_run(1'b0);
    chk({pulse_pin_out, counter_run_out}, {lvl(1'b0), 1'b0});
    $display("test one shot done");
    // Timer clock keeps ticking throughout capture use
    for (int f = 0; f < 4; f++) begin
      cfg(`MODE_CAPTURE, 2'(f), 1'(rnd()));
      n = 0;
      i0 = -1;
      repeat (3) begin
        fork
          partner.pulse_cap(8, 12);
          watch(20);
        join
      end
      flags_clr_in <= '0;
      chk(n, (f == 2) ? 6 : ((f == 3) ? 0 : 3));
      if (f < 2) chk(i0 >= 8, f == 1);
      chk({pfa, pulse_pin_out}, 2'b00);
    end
    compare_value_p_in <= 8'h01;
    cfg(`MODE_CAPTURE, `CAP_OFF, 1'(rnd()));
    n = 0;
    watch(600);
    chk({n, counter_value_out < 16'h0100}, {32'd2, 1'b1});
    wr_run(1'b0);
    step(1);
    a = counter_value_out;
    step(3);
    chk(counter_value_out, a);
    $display("test capture done");
    end_of_test();
  end
endmodule

`default_nettype wire
